// *** pcr_regs.sv ***
// Management registers: expanded control, event enables and flags, cable test start.
// Assumes a frame engine elsewhere presents one-cycle read and write strobes
// with a 5-bit register address; read data is valid the cycle after the strobe.

//////////////////////////////////////////////////////////////////////////////
module pcr_regs
  import pcr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [PCR_ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [PCR_DATA_W-1:0] i_reg_wdata,
  output logic [PCR_DATA_W-1:0] o_reg_rdata,
  input wire logic [PCR_EVT_N-1:0] i_events,
  output logic o_irq,
  output logic o_energy_sense_powerdown_disable,
  output logic o_cable_test_start,
  input wire logic i_cable_test_done,
  input wire logic i_speed_100,
  input wire logic i_rx_dv,
  input wire logic i_rx_er,
  input wire logic [3:0] i_rxd,
  output logic o_rx_dv,
  output logic o_rx_er,
  output logic [3:0] o_rxd
);

  function automatic logic hit(input logic [PCR_ADDR_W-1:0] addr,
                               input logic [4:0] off);
    hit = (addr == off);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Decode
  logic wr_exp;
  logic wr_evt;
  logic wr_cbl;
  logic rd_evt;
  logic rd_exp_sel;
  logic rd_evt_sel;
  logic rd_cbl_sel;

  assign wr_exp = i_reg_wr && hit(i_reg_addr, PCR_OFF_EXP_CTRL);
  assign wr_evt = i_reg_wr && hit(i_reg_addr, PCR_OFF_EVENT);
  assign wr_cbl = i_reg_wr && hit(i_reg_addr, PCR_OFF_CABLE);
  assign rd_exp_sel = hit(i_reg_addr, PCR_OFF_EXP_CTRL);
  assign rd_evt_sel = hit(i_reg_addr, PCR_OFF_EVENT);
  assign rd_cbl_sel = hit(i_reg_addr, PCR_OFF_CABLE);
  assign rd_evt = i_reg_rd && rd_evt_sel;

  //////////////////////////////////////////////////////////////////////////////
  // Expanded control, reserved bits kept as plain storage
  logic [15:0] exp_q;
  logic [15:0] exp_d;

  assign exp_d = wr_exp ? i_reg_wdata : exp_q;
  assign o_energy_sense_powerdown_disable = exp_q[PCR_EXP_PWRDN_DIS_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Event enables and flags
  logic [7:0] en_q;
  logic [7:0] en_d;
  logic [7:0] flag_q;
  logic [7:0] flag_d;

  assign en_d = wr_evt ? i_reg_wdata[PCR_EVT_EN_LSB +: PCR_EVT_N] : en_q;

  // Flags are read-only: writes to the low byte are ignored
  genvar g;
  generate
    for (g = 0; g < PCR_EVT_N; g++) begin : g_flag
      // Set wins over the read-clear so a same-cycle event is not lost
      assign flag_d[g] = i_events[g] || (flag_q[g] && !rd_evt);
    end
  endgenerate

  assign o_irq = |(flag_q & en_q);

  //////////////////////////////////////////////////////////////////////////////
  // Cable test start and reserved field
  logic start_q;
  logic start_d;
  logic [2:0] cbl_rsv_q;
  logic [2:0] cbl_rsv_d;

  // A fresh write of 1 beats a completion arriving in the same cycle
  assign start_d = (wr_cbl && i_reg_wdata[PCR_CBL_START_BIT]) ? 1'b1
                 : (i_cable_test_done ? 1'b0 : start_q);
  assign cbl_rsv_d = wr_cbl ? i_reg_wdata[PCR_CBL_RSV_LSB +: PCR_CBL_RSV_W] : cbl_rsv_q;
  assign o_cable_test_start = start_q;

  //////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read as zero
  logic [15:0] rd_mux;
  logic [15:0] rdata_d;

  assign rd_mux = rd_exp_sel ? exp_q
                : rd_evt_sel ? {en_q, flag_q}
                : rd_cbl_sel ? {start_q, 3'h0, cbl_rsv_q, 9'h000}
                : 16'h0000;
  assign rdata_d = i_reg_rd ? rd_mux : o_reg_rdata;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      exp_q <= PCR_EXP_CTRL_RST;
      en_q <= PCR_EVT_EN_RST;
      flag_q <= PCR_EVT_FLAG_RST;
      start_q <= PCR_CBL_START_RST;
      cbl_rsv_q <= PCR_CBL_RSV_RST;
      o_reg_rdata <= 16'h0000;
    end else begin
      exp_q <= exp_d;
      en_q <= en_d;
      flag_q <= flag_d;
      start_q <= start_d;
      cbl_rsv_q <= cbl_rsv_d;
      o_reg_rdata <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive preamble handling driven by the restore bits
  pcr_rx_trim u_rx_trim (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_speed_100(i_speed_100),
    .i_restore_100(exp_q[PCR_EXP_RESTORE_100_BIT]),
    .i_restore_10(exp_q[PCR_EXP_RESTORE_10_BIT]),
    .i_rx_dv(i_rx_dv),
    .i_rx_er(i_rx_er),
    .i_rxd(i_rxd),
    .o_rx_dv(o_rx_dv),
    .o_rx_er(o_rx_er),
    .o_rxd(o_rxd)
  );

endmodule

// *** pcr_pkg.sv ***
// Shared constants for the management control and event registers.
// Assumes a 5-bit management register address and 16-bit register data.
package pcr_pkg;

  localparam int unsigned PCR_ADDR_W = 5;
  localparam int unsigned PCR_DATA_W = 16;
  localparam int unsigned PCR_EVT_N = 8;

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [4:0] PCR_OFF_EXP_CTRL = 5'h18;
  localparam logic [4:0] PCR_OFF_EVENT = 5'h1b;
  localparam logic [4:0] PCR_OFF_CABLE = 5'h1d;

  //////////////////////////////////////////////////////////////////////////////
  // Expanded control fields and reset value
  localparam int unsigned PCR_EXP_PWRDN_DIS_BIT = 11;
  localparam int unsigned PCR_EXP_RESTORE_100_BIT = 10;
  localparam int unsigned PCR_EXP_RESTORE_10_BIT = 6;
  localparam logic [15:0] PCR_EXP_CTRL_RST = 16'h0800;

  //////////////////////////////////////////////////////////////////////////////
  // Event register: enables in the high byte, flags in the low byte.
  // Event order from high to low: jabber, receive error, page received,
  // parallel detect fault, partner acknowledge, link down, remote fault, link up.
  localparam int unsigned PCR_EVT_EN_LSB = 8;
  localparam int unsigned PCR_EVT_FLAG_LSB = 0;
  localparam logic [7:0] PCR_EVT_EN_RST = 8'h00;
  localparam logic [7:0] PCR_EVT_FLAG_RST = 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // Cable diagnostic register
  localparam int unsigned PCR_CBL_START_BIT = 15;
  localparam int unsigned PCR_CBL_RSV_LSB = 9;
  localparam int unsigned PCR_CBL_RSV_W = 3;
  localparam logic [2:0] PCR_CBL_RSV_RST = 3'h0;
  localparam logic PCR_CBL_START_RST = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // Receive preamble trimming, counted in MII nibbles
  localparam logic [4:0] PCR_DROP_100 = 5'h02;
  localparam logic [4:0] PCR_DROP_10 = 5'h0e;
  localparam logic [4:0] PCR_DROP_NONE = 5'h00;

endpackage

// *** pcr_rx_trim.sv ***
// Receive-path preamble trimmer in front of the MII receive outputs.
// Assumes nibble-wide receive data with a data-valid level, one nibble per cycle
// when valid, and the preamble arriving first after valid rises.
module pcr_rx_trim
  import pcr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_speed_100,
  input wire logic i_restore_100,
  input wire logic i_restore_10,
  input wire logic i_rx_dv,
  input wire logic i_rx_er,
  input wire logic [3:0] i_rxd,
  output logic o_rx_dv,
  output logic o_rx_er,
  output logic [3:0] o_rxd
);

  logic [4:0] drop_n;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic pass;

  // The restore bit of the current speed passes everything; otherwise a fixed per-speed count of leading nibbles is eaten
  assign drop_n = i_speed_100 ? (i_restore_100 ? PCR_DROP_NONE : PCR_DROP_100)
                              : (i_restore_10 ? PCR_DROP_NONE : PCR_DROP_10);
  assign pass = i_rx_dv && (cnt_q >= drop_n);
  // Counter saturates so long frames cannot wrap back into the drop window
  assign cnt_d = !i_rx_dv ? 5'h00 : ((cnt_q == 5'h1f) ? cnt_q : cnt_q + 5'h01);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q <= 5'h00;
      o_rx_dv <= 1'b0;
      o_rx_er <= 1'b0;
      o_rxd <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
      o_rx_dv <= pass;
      o_rx_er <= pass && i_rx_er;
      o_rxd <= pass ? i_rxd : 4'h0;
    end
  end

endmodule

// *** pcr_regs_monitor.sv ***
// Checker on the ports of pcr_regs, attached by bind below.
// Assumes one clock domain and one-cycle register strobes.
module pcr_regs_monitor
  import pcr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [PCR_ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [PCR_DATA_W-1:0] i_reg_wdata,
  input wire logic [PCR_DATA_W-1:0] o_reg_rdata,
  input wire logic [PCR_EVT_N-1:0] i_events,
  input wire logic o_irq,
  input wire logic o_energy_sense_powerdown_disable,
  input wire logic o_cable_test_start,
  input wire logic i_cable_test_done
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  wire logic pd = o_energy_sense_powerdown_disable;
  wire logic rd_evt = i_reg_rd && i_reg_addr == PCR_OFF_EVENT;
  wire logic wr_exp = i_reg_wr && i_reg_addr == PCR_OFF_EXP_CTRL;
  wire logic wr_cbl = i_reg_wr && i_reg_addr == PCR_OFF_CABLE && i_reg_wdata[15];
  pd_wr_a: assert property (wr_exp |=> pd == $past(i_reg_wdata[11]))
    else $error("powerdown bit wrong");
  rd_clear_a: assert property (rd_evt && i_events == 8'h00 |=> !o_irq)
    else $error("irq after read");
  evt_keep_a: assert property (rd_evt ##1 rd_evt |=> o_reg_rdata[7:0] == $past(i_events, 2))
    else $error("flag wrong on read");
  flag_set_a: assert property ((|i_events) ##1 rd_evt |=> &(o_reg_rdata[7:0] | ~$past(i_events, 2)))
    else $error("event flag missing");
  irq_up_a: assert property ($rose(o_irq) |-> $past(i_reg_wr || |i_events))
    else $error("irq without cause");
  irq_down_a: assert property ($fell(o_irq) |-> $past(rd_evt || i_reg_wr))
    else $error("irq dropped alone");
  cbl_start_a: assert property (wr_cbl |=> o_cable_test_start)
    else $error("cable start missing");
  cbl_done_a: assert property (i_cable_test_done && !wr_cbl |=> !o_cable_test_start)
    else $error("cable start stuck");
  cover property (rd_evt ##1 rd_evt);
  cover property (wr_cbl ##[1:20] i_cable_test_done);
  cover property ($fell(o_irq));
endmodule
bind pcr_regs pcr_regs_monitor mon (.*);

// *** pcr_mgmt_model.sv ***
// Management side: one-cycle register strobes, read data picked up after.
// Assumes read data settles before the falling edge after its strobe.
module pcr_mgmt_model
  import pcr_pkg::*;
(
  input wire logic i_clk,
  input wire logic [PCR_DATA_W-1:0] i_rdata,
  output logic [PCR_ADDR_W-1:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [PCR_DATA_W-1:0] o_wdata
);
  initial {o_addr, o_wr, o_rd, o_wdata} = '0;
  // n strobes back to back; write and read never share a cycle
  task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d,
    input int n, output logic [15:0] q);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= w;
    o_rd <= !w;
    repeat (n) @(posedge i_clk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    // Stale data would hide a missed sample
    o_wdata <= ~d;
    @(negedge i_clk);
    q = i_rdata;
  endtask
endmodule

// *** tb.sv ***
// Self-checking bench for pcr_regs driven through the management model.
// Assumes the checker is bound in its own file.
module tb
  import pcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [4:0] i_reg_addr;
  logic i_reg_wr, i_reg_rd, o_irq, o_energy_sense_powerdown_disable, o_cable_test_start;
  logic [15:0] i_reg_wdata, o_reg_rdata, q;
  logic [7:0] i_events = 8'h00;
  logic i_cable_test_done = 1'b0, i_speed_100 = 1'b1, i_rx_dv = 1'b0, i_rx_er = 1'b0;
  logic o_rx_dv, o_rx_er;
  logic [3:0] i_rxd = 4'h0, o_rxd, first;
  int errors = 0, n_compared = 0, n_out = 0;
  typedef struct packed {logic [4:0] a; logic w; logic [15:0] d; logic [15:0] e;} pcr_row_s;
  pcr_row_s rows[8] = '{'{5'h18, 0, 16'h0, 16'h0800}, '{5'h1b, 0, 16'h0, 16'h0},
    '{5'h1d, 0, 16'h0, 16'h0}, '{5'h18, 1, 16'hffff, 16'hffff}, '{5'h1b, 1, 16'hffff, 16'hff00},
    '{5'h1d, 1, 16'h7fff, 16'h0e00}, '{5'h05, 1, 16'hffff, 16'h0}, '{5'h18, 1, 16'h0, 16'h0}};
  // Speed, restore bits, nibbles dropped
  logic [21:0] frames[5] = '{{1'b1, 16'h0, 5'h02}, {1'b0, 16'h0, 5'h0e},
    {1'b1, 16'h0400, 5'h00}, {1'b0, 16'h0040, 5'h00}, {1'b1, 16'h0040, 5'h02}};
  pcr_regs uut (.*);
  pcr_mgmt_model mgmt (.i_clk, .i_rdata(o_reg_rdata), .o_addr(i_reg_addr), .o_wr(i_reg_wr),
    .o_rd(i_reg_rd), .o_wdata(i_reg_wdata));
  initial forever #50 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (o_rx_dv && n_out == 0) first = o_rxd;
    if (o_rx_dv) n_out++;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge i_clk);
    errors++;
    give_verdict();
  end
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b1;
    check(o_energy_sense_powerdown_disable, 1'b1);
    foreach (rows[i]) begin
      if (rows[i].w) mgmt.xfer(1'b1, rows[i].a, rows[i].d, 1, q);
      mgmt.xfer(1'b0, rows[i].a, 16'h0, 1, q);
      check(q, rows[i].e);
    end
    check(o_energy_sense_powerdown_disable, 1'b0);
    $display("table done");
    for (int k = 0; k < 8; k++) begin
      @(posedge i_clk) i_events <= 8'h01 << k;
      @(posedge i_clk) i_events <= 8'h00;
      @(negedge i_clk) check(o_irq, 1'b1);
      mgmt.xfer(1'b0, PCR_OFF_EVENT, 16'h0, 1, q);
      check(q, 16'hff00 | (16'h1 << k));
      check(o_reg_rdata, 16'hff00 | (16'h1 << k));
      check(o_irq, 1'b0);
    end
    // Event held across two back-to-back clearing reads
    @(posedge i_clk) i_events <= 8'h81;
    mgmt.xfer(1'b0, PCR_OFF_EVENT, 16'h0, 2, q);
    check(q, 16'hff81);
    @(posedge i_clk) i_events <= 8'h00;
    mgmt.xfer(1'b1, PCR_OFF_EVENT, 16'h0, 1, q);
    check(o_irq, 1'b0);
    $display("events done");
    mgmt.xfer(1'b1, PCR_OFF_CABLE, 16'h8000, 1, q);
    check(o_cable_test_start, 1'b1);
    @(posedge i_clk) i_cable_test_done <= 1'b1;
    @(posedge i_clk) i_cable_test_done <= 1'b0;
    @(negedge i_clk) check(o_cable_test_start, 1'b0);
    $display("cable done");
    foreach (frames[f]) begin
      mgmt.xfer(1'b1, PCR_OFF_EXP_CTRL, frames[f][20:5], 1, q);
      @(posedge i_clk) i_speed_100 <= frames[f][21];
      n_out = 0;
      for (int i = 0; i < 16; i++) begin
        @(posedge i_clk) i_rx_dv <= 1'b1;
        i_rxd <= 4'(i);
      end
      @(posedge i_clk) i_rx_dv <= 1'b0;
      repeat (3) @(posedge i_clk);
      check(n_out[15:0], 16'h10 - frames[f][4:0]);
      check({12'h0, first}, {11'h0, frames[f][4:0]});
    end
    $display("rx done");
    // Mid-run reset: flags 0x81 are still set and power-down bit is 0
    @(posedge i_clk) i_resetn <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(negedge i_clk) check(o_energy_sense_powerdown_disable, 1'b1);
    mgmt.xfer(1'b0, PCR_OFF_EVENT, 16'h0, 1, q);
    check(q, 16'h0000);
    $display("reset done");
    give_verdict();
  end
endmodule
